// >>> lmc_regs.svh
// Offsets, field positions, reset values and frame constants of the command decoder
`ifndef LMC_REGS_SVH
`define LMC_REGS_SVH

// Register byte offsets on the Wishbone slave
`define LMC_OFS_NODE        8'h00
`define LMC_OFS_IDS         8'h04
`define LMC_OFS_SECURE_POSITION_VALUE      8'h08
`define LMC_OFS_STATUS      8'h0C
`define LMC_OFS_LASTCMD     8'h10

// Field positions
`define LMC_IDS_STATUS_LSB  0
`define LMC_IDS_WRITE_LSB   8
`define LMC_ST_REFDONE_BIT  8
`define LMC_ST_OTPPEND_BIT  9
`define LMC_ST_FRMERR_BIT   10

// Reset values
`define LMC_RST_NODE        7'h00
`define LMC_RST_STATUS_ID   6'h10
`define LMC_RST_WRITE_ID    6'h00
`define LMC_RST_SECURE_POSITION_VALUE      11'h000

// Frame constants
`define LMC_ID_PREPARE      6'h3C
`define LMC_ID_INFRAME      6'h3D
`define LMC_APP_CMD         8'h80
`define LMC_CMD_PARAM_READ  7'h02
`define LMC_CMD_SECURE      7'h04
`define LMC_CMD_STOP        7'h05
`define LMC_CMD_POS_RESET   7'h06
`define LMC_PAD_BYTE        8'hFF
`define LMC_LEN_PREPARE     4'h8
`define LMC_LEN_WRITE       4'h2
`define LMC_LEN_OTP         4'h8
`define LMC_LEN_STATUS      4'h2

`endif

// >>> lmc_pkg.sv
// Types shared by the command decoder
package lmc_pkg;

    // Frame handling states
    typedef enum logic [1:0] {
        LMC_IDLE = 2'b00,
        LMC_RECV = 2'b01,
        LMC_SEND = 2'b10
    } lmc_state_t;

    // Kind of answer being sent
    typedef enum logic [0:0] {
        LMC_ANS_OTP    = 1'b0,
        LMC_ANS_STATUS = 1'b1
    } lmc_answer_t;

endpackage

// >>> lmc_decoder.sv
// Command decoder and in-frame responder of the bus-controlled stepper positioner
//
// Function
// - Preparing frame: 0x80, command 0x82, flagged node address, five FF pads.
// - Reading frame answer holds parameter bytes 0x00 to 0x07 ascending.
// - Parameter answer uses indirect identifier 0x3D.
// - Short status answered with two data bytes under a direct identifier.
// - Status byte 1: switch and address; byte 2: six flags, temperature info.
// - Reported status flags are cleared after a short status answer.
// - Writing frames use the general two-byte slot; command from data only.
// - Secure position command moves the motor to the stored 11-bit value.
// - Secure move also raised on bus loss, after init, before sleep.
// - Secure frame: command 0x84, then broadcast bit and node address.
// - Broadcast bit 0 makes every node take the secure move.
// - Coil fault triggers an immediate stop.
// - Stop while moving sets the step-loss flag.
// - Once stopped, actual position is copied into target position.
// - Stop frame: command 0x85, then broadcast bit and node address.
// - Broadcast bit 0 makes every node stop.
// - Position reset clears actual and target positions.
// - Position reset sets the reference-done flag.
// - Position reset frame: command 0x86, then broadcast bit and address.
// - Broadcast bit 0 makes every node reset its positions.
`timescale 1ns/1ps
`include "lmc_regs.svh"

module lmc_decoder #(
    parameter int BUF_DEPTH = 9
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        rx_start,
    input  wire logic [7:0]  rx_pid,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        tx_ready,
    output logic             tx_valid,
    output logic      [7:0]  tx_data,
    input  wire logic [63:0] otp_bytes,
    input  wire logic        motion_switch,
    input  wire logic [1:0]  temp_info,
    input  wire logic [5:0]  flag_events,
    input  wire logic        coil_fault,
    input  wire logic        motor_moving,
    input  wire logic        motor_stopped,
    input  wire logic        lin_lost,
    input  wire logic        init_done,
    input  wire logic        sleep_entry,
    input  wire logic        secure_inhibit,
    output logic             goto_secure,
    output logic      [10:0] secure_target,
    output logic             hard_stop,
    output logic             copy_act_to_tag,
    output logic             clear_positions,
    output logic             reference_done
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Classic checksum step: add with end-around carry; the caller inverts the sum
    function automatic logic [7:0] csum_add(input logic [7:0] acc, input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, acc} + {1'b0, b};
        return s[7:0] + {7'h00, s[8]};
    endfunction

    // Protected identifier parity check
    function automatic logic pid_ok(input logic [7:0] p);
        logic p0;
        logic p1;
        p0 = p[0] ^ p[1] ^ p[2] ^ p[4];
        p1 = ~(p[1] ^ p[3] ^ p[4] ^ p[5]);
        return (p[6] == p0) && (p[7] == p1);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    lmc_pkg::lmc_state_t  state_ff;
    lmc_pkg::lmc_answer_t ans_ff;
    logic [7:0]  buf_ff [BUF_DEPTH];
    logic [3:0]  cnt_ff;
    logic [3:0]  len_ff;
    logic [7:0]  sum_ff;
    logic [6:0]  node_ff;
    logic [5:0]  status_id_ff;
    logic [5:0]  write_id_ff;
    logic [10:0] secure_position_value_ff;
    logic [5:0]  flags_ff;
    logic [5:0]  reported_ff;
    logic [7:0]  status_b2_ff;
    logic        otp_pend_ff;
    logic        refdone_ff;
    logic        frmerr_ff;
    logic [7:0]  lastcmd_ff;
    logic        stop_wait_ff;
    logic        coil_ff;
    logic        tx_valid_ff;
    logic [7:0]  tx_data_ff;
    logic        goto_ff;
    logic        stop_ff;
    logic        copy_ff;
    logic        clr_ff;
    logic        ack_ff;
    logic [31:0] rdat_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave decode

    wire         wb_req    = wb_cyc_i && wb_stb_i && !ack_ff;
    wire         wb_wr     = wb_req && wb_we_i;
    wire         hit_node  = wb_adr_i == `LMC_OFS_NODE;
    wire         hit_ids   = wb_adr_i == `LMC_OFS_IDS;
    wire         hit_sec   = wb_adr_i == `LMC_OFS_SECURE_POSITION_VALUE;
    wire         hit_stat  = wb_adr_i == `LMC_OFS_STATUS;
    wire         hit_last  = wb_adr_i == `LMC_OFS_LASTCMD;
    wire [31:0]  rd_status = {21'h000000, frmerr_ff, otp_pend_ff, refdone_ff,
                              flags_ff, temp_info};
    // Unmapped offsets answer with zero data, never a stall
    wire [31:0]  rd_mux    = hit_node ? {25'h0000000, node_ff} :
                             hit_ids  ? {18'h00000, write_id_ff, 2'h0, status_id_ff} :
                             hit_sec  ? {21'h000000, secure_position_value_ff} :
                             hit_stat ? rd_status :
                             hit_last ? {24'h000000, lastcmd_ff} : 32'h00000000;

    ////////////////////////////////////////////////////////////////////////////
    // Frame header decode

    wire [5:0]   hdr_id     = rx_pid[5:0];
    wire         hdr_good   = rx_start && pid_ok(rx_pid);
    wire         hdr_prep   = hdr_id == `LMC_ID_PREPARE;
    wire         hdr_otp    = (hdr_id == `LMC_ID_INFRAME) && otp_pend_ff;
    wire         hdr_status = hdr_id == status_id_ff;
    wire         hdr_write  = hdr_id == write_id_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Reception

    wire         rx_take    = (state_ff == lmc_pkg::LMC_RECV) && rx_valid;
    wire         rx_last    = rx_take && (cnt_ff == len_ff);
    wire         sum_good   = rx_data == ~sum_ff;
    wire         frame_ok   = rx_last && sum_good;
    wire         frame_bad  = rx_last && !sum_good;

    // Preparing frame for the parameter read
    wire         prep_hit   = (len_ff == `LMC_LEN_PREPARE)
                              && (buf_ff[0] == `LMC_APP_CMD)
                              && (buf_ff[1] == {1'b1, `LMC_CMD_PARAM_READ})
                              && (buf_ff[2] == {1'b1, node_ff})
                              && (buf_ff[3] == `LMC_PAD_BYTE)
                              && (buf_ff[4] == `LMC_PAD_BYTE)
                              && (buf_ff[5] == `LMC_PAD_BYTE)
                              && (buf_ff[6] == `LMC_PAD_BYTE)
                              && (buf_ff[7] == `LMC_PAD_BYTE);

    // Two-byte writing frame: command in byte 1, broadcast and address in byte 2
    wire         wr_frame   = (len_ff == `LMC_LEN_WRITE) && buf_ff[0][7];
    wire         addr_match = !buf_ff[1][7] || (buf_ff[1][6:0] == node_ff);
    wire         wr_ok      = frame_ok && wr_frame && addr_match;
    wire         cmd_secure = wr_ok && (buf_ff[0][6:0] == `LMC_CMD_SECURE);
    wire         cmd_stop   = wr_ok && (buf_ff[0][6:0] == `LMC_CMD_STOP);
    wire         cmd_reset  = wr_ok && (buf_ff[0][6:0] == `LMC_CMD_POS_RESET);

    ////////////////////////////////////////////////////////////////////////////
    // Internal events

    wire         coil_rise  = coil_fault && !coil_ff;
    wire         stop_req   = cmd_stop || coil_rise;
    // Priority: a stop in the same cycle, or an external inhibit, drops the move
    wire         secure_req = (cmd_secure || lin_lost || init_done || sleep_entry)
                              && !secure_inhibit && !stop_req;
    wire         lost_steps = stop_req && motor_moving;

    ////////////////////////////////////////////////////////////////////////////
    // Transmission

    wire         tx_move    = tx_valid_ff && tx_ready;
    wire         tx_done    = tx_move && (cnt_ff == len_ff);
    wire [7:0]   status_b1  = {motion_switch, node_ff};
    wire [7:0]   status_b2  = {flags_ff, temp_info};
    wire [3:0]   cnt_next   = cnt_ff + 4'h1;
    wire [7:0]   otp_next   = otp_bytes[{cnt_next[2:0], 3'b000} +: 8];
    wire [7:0]   tx_byte    = (cnt_next == len_ff) ? ~csum_add(sum_ff, tx_data_ff) :
                              (ans_ff == lmc_pkg::LMC_ANS_OTP) ? otp_next :
                              status_b2_ff;
    // Flags reported in a finished status answer are dropped; new events win
    wire [5:0]   flag_clr   = (tx_done && (ans_ff == lmc_pkg::LMC_ANS_STATUS)) ?
                              reported_ff : 6'h00;
    wire [5:0]   flag_set   = flag_events | {1'b0, lost_steps, 4'h0};
    wire [5:0]   nxt_flags  = (flags_ff & ~flag_clr) | flag_set;

    ////////////////////////////////////////////////////////////////////////////
    // Frame state machine
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= lmc_pkg::LMC_IDLE;
            ans_ff   <= lmc_pkg::LMC_ANS_OTP;
            cnt_ff   <= 4'h0;
            len_ff   <= 4'h0;
            sum_ff   <= 8'h00;
        end else if (hdr_good && hdr_prep) begin
            state_ff <= lmc_pkg::LMC_RECV;
            cnt_ff   <= 4'h0;
            len_ff   <= `LMC_LEN_PREPARE;
            sum_ff   <= 8'h00;
        end else if (hdr_good && hdr_otp) begin
            state_ff <= lmc_pkg::LMC_SEND;
            ans_ff   <= lmc_pkg::LMC_ANS_OTP;
            cnt_ff   <= 4'h0;
            len_ff   <= `LMC_LEN_OTP;
            sum_ff   <= 8'h00;
        end else if (hdr_good && hdr_status) begin
            state_ff <= lmc_pkg::LMC_SEND;
            ans_ff   <= lmc_pkg::LMC_ANS_STATUS;
            cnt_ff   <= 4'h0;
            len_ff   <= `LMC_LEN_STATUS;
            sum_ff   <= 8'h00;
        end else if (hdr_good && hdr_write) begin
            state_ff <= lmc_pkg::LMC_RECV;
            cnt_ff   <= 4'h0;
            len_ff   <= `LMC_LEN_WRITE;
            sum_ff   <= 8'h00;
        end else if (rx_start) begin
            state_ff <= lmc_pkg::LMC_IDLE; // Foreign or corrupt header
        end else if (rx_last || tx_done) begin
            state_ff <= lmc_pkg::LMC_IDLE;
        end else if (rx_take) begin
            cnt_ff   <= cnt_next;
            sum_ff   <= csum_add(sum_ff, rx_data);
        end else if (tx_move) begin
            cnt_ff   <= cnt_next;
            sum_ff   <= csum_add(sum_ff, tx_data_ff);
        end
    end

    // Receive buffer, indexed by byte count
    always_ff @(posedge clk) begin
        if (rx_take && !rx_last) begin
            buf_ff[cnt_ff] <= rx_data;
        end
    end

    // Answer byte stream; first byte loaded with the header
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_valid_ff  <= 1'b0;
            tx_data_ff   <= 8'h00;
            status_b2_ff <= 8'h00;
            reported_ff  <= 6'h00;
        end else if (hdr_good && hdr_otp) begin
            tx_valid_ff  <= 1'b1;
            tx_data_ff   <= otp_bytes[7:0];
        end else if (hdr_good && hdr_status && !hdr_prep) begin
            tx_valid_ff  <= 1'b1;
            tx_data_ff   <= status_b1;
            status_b2_ff <= status_b2;
            reported_ff  <= flags_ff; // Snapshot of what this answer reports
        end else if (rx_start || tx_done) begin
            tx_valid_ff  <= 1'b0;
        end else if (tx_move) begin
            tx_data_ff   <= tx_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status flags and command results
    always_ff @(posedge clk) begin
        if (rst) begin
            flags_ff    <= 6'h00;
            otp_pend_ff <= 1'b0;
            refdone_ff  <= 1'b0;
            frmerr_ff   <= 1'b0;
            lastcmd_ff  <= 8'h00;
        end else begin
            flags_ff    <= nxt_flags;
            if (frame_ok && prep_hit) begin
                otp_pend_ff <= 1'b1;
            end else if (tx_done && (ans_ff == lmc_pkg::LMC_ANS_OTP)) begin
                otp_pend_ff <= 1'b0;
            end
            if (cmd_reset) begin
                refdone_ff <= 1'b1;
            end
            // Sticky, cleared by writing one to it; a new error wins
            if (frame_bad) begin
                frmerr_ff <= 1'b1;
            end else if (wb_wr && hit_stat && wb_sel_i[1]
                         && wb_dat_i[`LMC_ST_FRMERR_BIT]) begin
                frmerr_ff <= 1'b0;
            end
            if (wr_ok) begin
                lastcmd_ff <= buf_ff[0];
            end
        end
    end

    // Stop handling: copy position once the motor reports standstill
    always_ff @(posedge clk) begin
        if (rst) begin
            coil_ff      <= 1'b0;
            stop_wait_ff <= 1'b0;
            stop_ff      <= 1'b0;
            copy_ff      <= 1'b0;
            goto_ff      <= 1'b0;
            clr_ff       <= 1'b0;
        end else begin
            coil_ff      <= coil_fault;
            stop_ff      <= stop_req;
            goto_ff      <= secure_req;
            clr_ff       <= cmd_reset;
            copy_ff      <= stop_wait_ff && motor_stopped;
            if (stop_req) begin
                stop_wait_ff <= 1'b1;
            end else if (motor_stopped) begin
                stop_wait_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software registers
    always_ff @(posedge clk) begin
        if (rst) begin
            node_ff      <= `LMC_RST_NODE;
            status_id_ff <= `LMC_RST_STATUS_ID;
            write_id_ff  <= `LMC_RST_WRITE_ID;
            secure_position_value_ff    <= `LMC_RST_SECURE_POSITION_VALUE;
        end else begin
            if (wb_wr && hit_node && wb_sel_i[0]) begin
                node_ff <= wb_dat_i[6:0];
            end
            if (wb_wr && hit_ids && wb_sel_i[0]) begin
                status_id_ff <= wb_dat_i[`LMC_IDS_STATUS_LSB +: 6];
            end
            if (wb_wr && hit_ids && wb_sel_i[1]) begin
                write_id_ff <= wb_dat_i[`LMC_IDS_WRITE_LSB +: 6];
            end
            if (wb_wr && hit_sec && wb_sel_i[0]) begin
                secure_position_value_ff[7:0] <= wb_dat_i[7:0];
            end
            if (wb_wr && hit_sec && wb_sel_i[1]) begin
                secure_position_value_ff[10:8] <= wb_dat_i[10:8];
            end
        end
    end

    // Reference done output, masked one cycle by a clear write; a position reset wins
    logic refout_ff;
    always_ff @(posedge clk) begin
        if (rst) begin
            refout_ff <= 1'b0;
        end else begin
            refout_ff <= cmd_reset || (refdone_ff && !(wb_wr && hit_stat
                         && wb_sel_i[1] && wb_dat_i[`LMC_ST_REFDONE_BIT]));
        end
    end

    // Single-cycle answer, dropped the cycle after
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_ff  <= 1'b0;
            rdat_ff <= 32'h00000000;
        end else begin
            ack_ff  <= wb_req;
            rdat_ff <= wb_req ? rd_mux : 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all from flops
    assign wb_dat_o        = rdat_ff;
    assign wb_ack_o        = ack_ff;
    assign tx_valid        = tx_valid_ff;
    assign tx_data         = tx_data_ff;
    assign goto_secure     = goto_ff;
    assign secure_target   = secure_position_value_ff;
    assign hard_stop       = stop_ff;
    assign copy_act_to_tag = copy_ff;
    assign clear_positions = clr_ff;
    assign reference_done  = refout_ff;

endmodule // lmc_decoder

// >>> lmc_decoder_monitor.sv
// Port checker of the command decoder, bound to its top module
`timescale 1ns/1ps

module lmc_decoder_monitor (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic        tx_ready,
    input wire logic        tx_valid,
    input wire logic [7:0]  tx_data,
    input wire logic        coil_fault,
    input wire logic        lin_lost,
    input wire logic        init_done,
    input wire logic        sleep_entry,
    input wire logic        secure_inhibit,
    input wire logic        goto_secure,
    input wire logic        hard_stop,
    input wire logic        clear_positions,
    input wire logic        reference_done
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////////
    // Bus handshake: fixed one-cycle answer, data bus quiet between answers
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    read_quiet_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero outside ack");
    // Answer bytes must not move while the framing layer stalls
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("answer byte changed while stalled");
    tx_drop_a: assert property ($fell(tx_valid) |-> $past(tx_ready))
        else $error("answer dropped before last byte taken");
    // Internal triggers of the stop and secure move, and reference done after a position clear
    fault_stop_a: assert property ($rose(coil_fault) |-> ##[1:2] hard_stop)
        else $error("coil fault gave no stop");
    stop_pulse_a: assert property (hard_stop |=> !hard_stop)
        else $error("stop pulse longer than one cycle");
    auto_move_a: assert property ((lin_lost || init_done || sleep_entry) && !secure_inhibit
        |-> ##[1:2] (goto_secure || hard_stop))
        else $error("internal secure move missing");
    refdone_set_a: assert property (clear_positions |-> ##[1:2] reference_done)
        else $error("reference done not set after clear");

    cover property (goto_secure);
    cover property (hard_stop);
    cover property (clear_positions);
    cover property (tx_valid && tx_ready);
endmodule // lmc_decoder_monitor

bind lmc_decoder lmc_decoder_monitor mon (
    .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .coil_fault(coil_fault), .lin_lost(lin_lost), .init_done(init_done),
    .sleep_entry(sleep_entry), .secure_inhibit(secure_inhibit), .goto_secure(goto_secure),
    .hard_stop(hard_stop), .clear_positions(clear_positions), .reference_done(reference_done)
);

// >>> lmc_master_model.sv
// Behavioural bus master node that sends frames and collects in-frame answers
`timescale 1ns/1ps

module lmc_master_model (
    input  wire logic       clk,
    output logic            rx_start,
    output logic [7:0]      rx_pid,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            tx_ready,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data
);
    logic [7:0] got [10];
    int         n_got = 0;
    logic       slow  = 1'b0;

    initial begin
        {rx_start, rx_valid, tx_ready} = 3'b000;
        rx_pid  = 8'h00;
        rx_data = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Protected identifier and classic checksum
    function automatic logic [7:0] pid_of(input logic [5:0] id);
        return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
    endfunction

    function automatic logic [7:0] csum(input logic [7:0] d [10], input int n);
        logic [8:0] s;
        s = 9'h000;
        for (int i = 0; i < n; i++) begin
            s = s[7:0] + d[i];
            s = s[7:0] + s[8];
        end
        return ~s[7:0];
    endfunction

    // Header pulse; pid turned over afterwards so a stale value never looks valid
    task automatic header(input logic [5:0] id);
        @(posedge clk);
        rx_start <= 1'b1;
        rx_pid   <= pid_of(id);
        @(posedge clk);
        rx_start <= 1'b0;
        rx_pid   <= ~pid_of(id);
    endtask

    // Writing or preparing frame, optionally with a broken checksum
    task automatic send(input logic [5:0] id, input logic [7:0] d [10], input int n,
                        input logic bad);
        logic [7:0] c;
        c = csum(d, n) ^ {7'h00, bad};
        header(id);
        for (int i = 0; i <= n; i++) begin
            rx_valid <= 1'b1;
            rx_data  <= (i == n) ? c : d[i];
            @(posedge clk);
        end
        rx_valid <= 1'b0;
        rx_data  <= ~c;
    endtask

    // Reading frame; slow mode stalls every other cycle
    task automatic fetch(input logic [5:0] id);
        header(id);
        n_got = 0;
        repeat (40) begin
            tx_ready <= slow ? ~tx_ready : 1'b1;
            @(posedge clk);
            if (tx_valid === 1'b1 && tx_ready === 1'b1 && n_got < 10) begin
                got[n_got] = tx_data;
                n_got++;
            end
        end
        tx_ready <= 1'b0;
    endtask
endmodule // lmc_master_model

// >>> lin_motor_command_decoder_tb.sv
// Self-checking bench of the command decoder with a bus master model
`timescale 1ns/1ps
`include "lmc_regs.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end

module lin_motor_command_decoder_tb;
    localparam logic [63:0] OTP = 64'h8877_6655_4433_2211;
    logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00, rx_pid, rx_data, tx_data;
    logic [31:0] wdat = 32'h0000_0000, rd, wb_dat_o;
    logic        wb_ack_o, rx_start, rx_valid, tx_ready, tx_valid, gs, hs, cp, clp, rdn;
    logic        msw = 1'b1, mov = 1'b0, stp = 1'b0, ll = 1'b0, ini = 1'b0, slp = 1'b0;
    logic        inh = 1'b0, cf = 1'b0;
    logic [5:0]  fev = 6'h00;
    logic [1:0]  tin = 2'b10;
    logic [10:0] st;
    logic [7:0]  d [10];
    int          err_count = 0, n_compared = 0, pc [4] = '{0, 0, 0, 0}, b [4];
    logic [7:0]  ra [4] = '{`LMC_OFS_NODE, `LMC_OFS_IDS, `LMC_OFS_SECURE_POSITION_VALUE, 8'h20};
    logic [31:0] rv [4] = '{32'h0, 32'h10, 32'h0, 32'h0};
    logic [7:0]  fc [7] = '{8'h84, 8'h84, 8'h84, 8'h85, 8'h86, 8'h84, 8'h85};
    logic [7:0]  fa [7] = '{8'h95, 8'h33, 8'hB3, 8'h95, 8'h2A, 8'h95, 8'h44};
    int          fx [7] = '{0, 0, 4, 1, 2, 4, 1};

    always #25 clk = ~clk;

    lmc_decoder dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .rx_start(rx_start), .rx_pid(rx_pid), .rx_valid(rx_valid),
        .rx_data(rx_data), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
        .otp_bytes(OTP), .motion_switch(msw), .temp_info(tin), .flag_events(fev),
        .coil_fault(cf), .motor_moving(mov), .motor_stopped(stp), .lin_lost(ll),
        .init_done(ini), .sleep_entry(slp), .secure_inhibit(inh), .goto_secure(gs),
        .secure_target(st), .hard_stop(hs), .copy_act_to_tag(cp),
        .clear_positions(clp), .reference_done(rdn));

    lmc_master_model m (.clk(clk), .rx_start(rx_start), .rx_pid(rx_pid),
        .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data));

    ////////////////////////////////////////////////////////////////////////////////
    // Pulse counters; pulses are one cycle, so counting avoids edge races
    always @(posedge clk) begin
        pc[0] += (gs === 1'b1);
        pc[1] += (hs === 1'b1);
        pc[2] += (clp === 1'b1);
        pc[3] += (cp === 1'b1);
    end

    // Classic Wishbone cycle; waits for ack with no assumed latency
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, v};
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        {cyc, stb} <= 2'b00;
    endtask

    task automatic frame(input logic [7:0] c, input logic [7:0] a, input logic bad);
        d[0] = c;
        d[1] = a;
        m.send(6'h00, d, 2, bad);
        repeat (3) @(posedge clk);
    endtask

    // Answer bytes against d, last byte against the checksum
    task automatic chk_tx(input int n);
        `CHK("answer length", n, m.n_got)
        for (int i = 0; i < n - 1; i++) `CHK("answer byte", d[i], m.got[i])
        `CHK("answer checksum", m.csum(d, n - 1), m.got[n - 1])
    endtask

    task automatic final_report;
        if (err_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Hang guard, far beyond the few hundred cycles of the sequence
    initial begin
        #2000000;
        err_count++;
        final_report();
    end

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            wb(1'b0, ra[i], 32'h0);
            `CHK("reset value", rv[i], rd)
        end
        wb(1'b1, `LMC_OFS_NODE, 32'h15);
        wb(1'b1, `LMC_OFS_SECURE_POSITION_VALUE, 32'h2AB);
        @(posedge clk);
        `CHK("secure target", 11'h2AB, st)
        mov <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            b = pc;
            frame(fc[i], fa[i], i == 5);
            for (int k = 0; k < 3; k++)
                `CHK("pulse count", b[k] + (fx[i] == k), pc[k])
        end
        `CHK("reference done", 1'b1, rdn)
        wb(1'b0, `LMC_OFS_STATUS, 32'h0);
        `CHK("status word", {3'b101, 6'h10, 2'b10}, rd[10:0])
        wb(1'b0, `LMC_OFS_LASTCMD, 32'h0);
        `CHK("last command", 8'h85, rd[7:0])
        @(posedge clk) fev <= 6'h2D;
        @(posedge clk) fev <= 6'h00;
        m.fetch(6'h10);
        d[0] = 8'h95;
        d[1] = 8'hF6;
        chk_tx(3);
        m.slow = 1'b1;
        m.fetch(6'h10);
        d[1] = 8'h02;
        chk_tx(3);
        m.fetch(`LMC_ID_INFRAME);
        `CHK("unprepared answer", 0, m.n_got)
        d = '{8'h80, 8'h82, 8'h95, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00};
        m.send(`LMC_ID_PREPARE, d, 8, 1'b0);
        m.fetch(`LMC_ID_INFRAME);
        for (int i = 0; i < 8; i++) d[i] = OTP[8 * i +: 8];
        chk_tx(9);
        b = pc;
        @(posedge clk) ll <= 1'b1;
        @(posedge clk) {ll, inh, ini} <= 3'b011;
        @(posedge clk) {ini, inh, slp} <= 3'b001;
        @(posedge clk) slp <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK("internal moves", b[0] + 2, pc[0])
        @(posedge clk) cf <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("fault stops", b[1] + 1, pc[1])
        stp <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("position copy", 1'b1, pc[3] > 0)
        final_report();
    end
endmodule // lin_motor_command_decoder_tb
